// ---- shared/rgds_pkg.sv ----
// Purpose: constants and types for the rail group delay sequencer
// Assumes: 100 MHz system clock
// Notes: register offsets are the device's I2C register addresses
package rgds_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  // timebase tick of 0.25 ms, in microseconds
  localparam int unsigned TICK_US = 250;
  localparam int unsigned TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * TICK_US;
  localparam int unsigned NUM_TYPES = 4;
  localparam logic [3:0] LAST_GROUP = 4'he;
  localparam logic [3:0] GROUP_DISABLED = 4'hf;
  localparam logic [2:0] DEFAULT_DELAY_CODE = 3'h2;
  // register addresses
  localparam logic [7:0] ADDR_FIRST_TIER_TIM = 8'hc3;
  localparam logic [7:0] ADDR_SECOND_TIER_TIM = 8'hc4;
  localparam logic [7:0] ADDR_THIRD_TIER_TIM = 8'hd3;
  localparam logic [7:0] ADDR_FOURTH_TIER_TIM = 8'hd4;
  // field positions in a timing register
  localparam int unsigned ON_CODE_LSB = 0;
  localparam int unsigned OFF_CODE_LSB = 4;
  localparam logic [7:0] TIM_WRITE_MASK = 8'h77;

  // one timing register: bit 7 and bit 3 reserved
  typedef struct packed {
    logic rsvd_hi;
    logic [2:0] turn_off_step_delay_code;
    logic rsvd_lo;
    logic [2:0] turn_on_step_delay_code;
  } rgds_tim_t;

  // register write/read port
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rgds_reg_req_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_WAIT = 3'h2,
    SEQ_STEP = 3'h4
  } rgds_seq_state_t;

  // number of 0.25 ms ticks for a delay code
  function automatic logic [4:0] rgds_code_ticks(input logic [2:0] code);
    case (code)
      3'h0: rgds_code_ticks = 5'h01;
      3'h1: rgds_code_ticks = 5'h02;
      3'h2: rgds_code_ticks = 5'h04;
      3'h3: rgds_code_ticks = 5'h06;
      3'h4: rgds_code_ticks = 5'h08;
      3'h5: rgds_code_ticks = 5'h0a;
      3'h6: rgds_code_ticks = 5'h0c;
      default: rgds_code_ticks = 5'h14;
    endcase
  endfunction : rgds_code_ticks
endpackage : rgds_pkg

// ---- hw/rgds_type_stepper.sv ----
// Purpose: steps one rail type through its group indexes
// Assumes: tick_i is a one-cycle pulse every 0.25 ms
// Notes: the index rises 0..14 on wake and falls 14..0 on sleep
module rgds_type_stepper
  import rgds_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // timing
  input wire logic tick_i,
  input wire logic [2:0] on_code_i,
  input wire logic [2:0] off_code_i,
  // request: high means rails of this type should be up
  input wire logic up_req_i,
  // status
  output logic [3:0] group_index_o,
  output logic all_on_o,
  output logic any_on_o
);
  rgds_seq_state_t state, next_state;
  logic [3:0] idx, next_idx;
  logic lit, next_lit;
  logic [4:0] ticks, next_ticks;
  logic [4:0] target;

  // delay in use depends on direction
  assign target = up_req_i ? rgds_code_ticks(on_code_i) : rgds_code_ticks(off_code_i);

  // next-state logic of the group walker
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_lit = lit;
    next_ticks = ticks;
    case (state)
      SEQ_IDLE: begin
        if (up_req_i && !(lit && idx == LAST_GROUP)) begin
          if (!lit) begin
            next_lit = 1'b1; // index 0 enables at once
            next_idx = 4'h0;
          end else begin
            next_state = SEQ_WAIT;
            next_ticks = 5'h00;
          end
        end else if (!up_req_i && lit) begin
          next_state = SEQ_WAIT;
          next_ticks = 5'h00;
        end
      end
      SEQ_WAIT: begin
        if (tick_i) begin
          next_ticks = ticks + 5'h01;
        end
        if (tick_i && (ticks + 5'h01) >= target) begin
          next_state = SEQ_STEP;
        end
      end
      SEQ_STEP: begin
        next_state = SEQ_IDLE;
        if (up_req_i) begin
          // a wake that comes back at the last group has nowhere further to go
          if (idx != LAST_GROUP) begin
            next_idx = idx + 4'h1;
          end
        end else if (idx == 4'h0) begin
          next_lit = 1'b0;
        end else begin
          next_idx = idx - 4'h1;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  // registers of the group walker
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state <= SEQ_IDLE;
      idx <= 4'h0;
      lit <= 1'b0;
      ticks <= 5'h00;
      group_index_o <= GROUP_DISABLED;
      all_on_o <= 1'b0;
      any_on_o <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      lit <= next_lit;
      ticks <= next_ticks;
      group_index_o <= next_lit ? next_idx : GROUP_DISABLED;
      all_on_o <= next_lit && next_idx == LAST_GROUP;
      any_on_o <= next_lit;
    end
  end

  chk_step_after_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    state == SEQ_STEP |-> $past(tick_i) && $past(ticks) + 5'h01 >= $past(target))
    else $error("group index advanced before delay elapsed");
  chk_index_bounded: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    lit |-> idx <= LAST_GROUP)
    else $error("group index passed last group");
  chk_walk_direction: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    state == SEQ_STEP && up_req_i |=> idx == ($past(idx) == LAST_GROUP ? LAST_GROUP : $past(idx) + 4'h1))
    else $error("wake walk not ascending");
  chk_sleep_direction: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    state == SEQ_STEP && !up_req_i && idx != 4'h0 |=> idx == $past(idx) - 4'h1)
    else $error("sleep walk not descending");
endmodule : rgds_type_stepper

// ---- hw/rgds_sequencer.sv ----
// Purpose: group delay timing core of a four-type power rail sequencer
// Assumes: register port comes from the device's I2C slave, synchronous to sys_clk_i
// Notes: nonvolatile defaults arrive on nv_on_code_i and are sampled at reset release
// Notes: host writes in the reload cycle are dropped; unmapped reads return zero
// Notes: one walker per rail type, all paced by a shared 0.25 ms tick
// Contract
// - one timing register per rail type sets the wait between consecutive group indexes of that type.
// - turn-on code in bits 2:0 maps 000..111 to 0.25,0.5,1,1.5,2,2.5,3,5 ms, 010 being 1 ms.
// - turn-off code in bits 6:4 uses the same scale, and bits 7 and 3 are reserved.
// - at power-up each turn-off field is loaded with the nonvolatile turn-on value of its type.
// - a turn-off field rewritten by the host applies to later turn-off walks of that type.
// - each type has fifteen group indexes, so a full wake walk lasts fourteen group delays and a full sleep walk fifteen.
// - on wake each type walks indexes 0 up to 14, one group delay apart.
// - on sleep each type walks back down in reverse order with the turn-off delay.
// - power state reads 0000, 0001, 0011, 0111 or 1111 as tiers come fully on.
module rgds_sequencer
  import rgds_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // nonvolatile turn-on codes, one per type
  input wire logic [NUM_TYPES*3-1:0] nv_on_code_i,
  // register port
  input wire rgds_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // tier requests from the host side; low on a tier means sleep
  input wire logic [NUM_TYPES-1:0] tier_up_req_i,
  // outputs
  output logic [NUM_TYPES*4-1:0] group_index_o,
  output logic [3:0] power_state_code_o
);
  rgds_tim_t tim [NUM_TYPES];
  rgds_tim_t next_tim [NUM_TYPES];
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic loaded, next_loaded;
  logic [7:0] next_rdata;
  logic [3:0] next_state_code;
  logic [NUM_TYPES-1:0] all_on;
  logic [NUM_TYPES-1:0] any_on;
  logic [NUM_TYPES*4-1:0] grp;

  // map register address to type index, 4 when unmapped
  function automatic logic [2:0] addr_type(input logic [7:0] a);
    if (a == ADDR_FIRST_TIER_TIM) begin
      addr_type = 3'h0;
    end else if (a == ADDR_SECOND_TIER_TIM) begin
      addr_type = 3'h1;
    end else if (a == ADDR_THIRD_TIER_TIM) begin
      addr_type = 3'h2;
    end else if (a == ADDR_FOURTH_TIER_TIM) begin
      addr_type = 3'h3;
    end else begin
      addr_type = 3'h4;
    end
  endfunction : addr_type

  // timebase of 0.25 ms
  // the tick is registered so that every walker sees it in the same cycle
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h1;
    if (tick_cnt >= TICK_LEN - 1) begin
      next_tick_cnt = 32'h0;
      next_tick = 1'b1;
    end
  end

  // timing registers: load from nonvolatile then host writes
  // the reload cycle wins over a host write, so a write that early is dropped
  always_comb begin
    logic [2:0] t;
    logic [2:0] nv;
    t = addr_type(reg_req_i.addr);
    nv = 3'h0;
    next_loaded = 1'b1;
    for (int i = 0; i < NUM_TYPES; i++) begin
      nv = nv_on_code_i[i*3 +: 3];
      next_tim[i] = tim[i];
      if (!loaded) begin
        next_tim[i] = '0;
        next_tim[i].turn_on_step_delay_code = nv;
        next_tim[i].turn_off_step_delay_code = nv;
      end else if (reg_req_i.wr_en && t == 3'(i)) begin
        next_tim[i] = rgds_tim_t'(reg_req_i.wdata & TIM_WRITE_MASK);
      end
    end
    next_rdata = 8'h00;
    if (reg_req_i.rd_en && t < 3'h4) begin
      next_rdata = tim[t[1:0]];
    end
  end

  // power state from fully-on tiers, lower tiers first
  // a tier counts only at its last group, so the code never runs ahead of the rails
  always_comb begin
    next_state_code = 4'h0;
    if (all_on[0]) begin
      next_state_code = 4'h1;
      if (all_on[1]) begin
        next_state_code = 4'h3;
        if (all_on[2]) begin
          next_state_code = 4'h7;
          if (all_on[3]) begin
            next_state_code = 4'hf;
          end
        end
      end
    end
  end

  // registers of the core
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
      loaded <= 1'b0;
      for (int i = 0; i < NUM_TYPES; i++) begin
        tim[i] <= '0;
      end
      reg_rdata_o <= 8'h00;
      power_state_code_o <= 4'h0;
      group_index_o <= '1;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      loaded <= next_loaded;
      tim <= next_tim;
      reg_rdata_o <= next_rdata;
      power_state_code_o <= next_state_code;
      group_index_o <= grp;
    end
  end

  // one walker per rail type, each on its own timing register
  // a walker stays parked until the reload has set its codes
  for (genvar g = 0; g < NUM_TYPES; g++) begin : gen_type
    rgds_type_stepper u_step (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick),
      .on_code_i(tim[g].turn_on_step_delay_code),
      .off_code_i(tim[g].turn_off_step_delay_code),
      .up_req_i(tier_up_req_i[g] && loaded),
      .group_index_o(grp[g*4 +: 4]),
      .all_on_o(all_on[g]),
      .any_on_o(any_on[g])
    );
  end

  // timebase checks
  chk_tick_period: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    tick |=> !tick)
    else $error("timebase tick longer than one cycle");
  chk_tick_phase: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    tick |-> tick_cnt == 32'h0)
    else $error("timebase tick out of phase with its counter");

  // reload of the timing registers after reset
  chk_off_loaded: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(loaded) |-> tim[0].turn_off_step_delay_code == tim[0].turn_on_step_delay_code
      && tim[1].turn_off_step_delay_code == tim[1].turn_on_step_delay_code
      && tim[2].turn_off_step_delay_code == tim[2].turn_on_step_delay_code
      && tim[3].turn_off_step_delay_code == tim[3].turn_on_step_delay_code)
    else $error("turn-off code not loaded from turn-on value");
  chk_on_loaded: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(loaded) |-> tim[0].turn_on_step_delay_code == $past(nv_on_code_i[2:0])
      && tim[1].turn_on_step_delay_code == $past(nv_on_code_i[5:3])
      && tim[2].turn_on_step_delay_code == $past(nv_on_code_i[8:6])
      && tim[3].turn_on_step_delay_code == $past(nv_on_code_i[11:9]))
    else $error("turn-on code not taken from nonvolatile value");
  chk_loaded_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    loaded |=> loaded)
    else $error("reload repeated without a reset");
  chk_parked_until_load: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !loaded |=> group_index_o == {NUM_TYPES{GROUP_DISABLED}})
    else $error("rail type walked before its codes were loaded");

  // register port checks
  chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !tim[0].rsvd_hi && !tim[0].rsvd_lo && !tim[1].rsvd_hi && !tim[1].rsvd_lo
      && !tim[2].rsvd_hi && !tim[2].rsvd_lo && !tim[3].rsvd_hi && !tim[3].rsvd_lo)
    else $error("reserved timing bit set");
  chk_write_lands: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    loaded && reg_req_i.wr_en && reg_req_i.addr == ADDR_FIRST_TIER_TIM
      |=> tim[0] == rgds_tim_t'($past(reg_req_i.wdata) & TIM_WRITE_MASK))
    else $error("write to first tier timing register lost");
  chk_stray_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    loaded && reg_req_i.wr_en && addr_type(reg_req_i.addr) == 3'h4
      |=> tim[0] == $past(tim[0]))
    else $error("write to an unmapped address changed a timing register");
  chk_read_data: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    reg_req_i.rd_en && reg_req_i.addr == ADDR_SECOND_TIER_TIM |=> reg_rdata_o == $past(tim[1]))
    else $error("read data does not match second tier timing register");
  chk_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !reg_req_i.rd_en |=> reg_rdata_o == 8'h00)
    else $error("read data shown outside a read cycle");

  // power state and index checks
  chk_state_code: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    power_state_code_o == 4'hf |-> $past(all_on) == 4'hf)
    else $error("power state code claims all tiers on");
  chk_state_ladder: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    power_state_code_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("power state code off the tier ladder");
  chk_state_order: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !all_on[0] |=> power_state_code_o == 4'h0)
    else $error("power state counts tiers above a first tier not fully on");
  chk_state_second: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !all_on[1] |=> power_state_code_o[3:1] == 3'h0)
    else $error("power state counts tiers above a second tier not fully on");
  chk_state_third: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !all_on[2] |=> power_state_code_o[3:2] == 2'h0)
    else $error("power state counts tiers above a third tier not fully on");
  chk_off_index: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !any_on[0] |=> group_index_o[3:0] == GROUP_DISABLED)
    else $error("first tier all off yet shows a group index");
  chk_top_off_index: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !any_on[3] |=> group_index_o[15:12] == GROUP_DISABLED)
    else $error("fourth tier all off yet shows a group index");
endmodule : rgds_sequencer

// ---- verif/rgds_host_model.sv ----
// Purpose: host side model driving the per-tier up request lines
// Assumes: bench sets want_up_i just after a rising edge
// Notes: a dropped request is held low for MIN_LOW+1 cycles before it may rise
module rgds_host_model
  import rgds_pkg::*;
#(
  parameter int unsigned MIN_LOW = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // bench wishes, one per tier
  input wire logic [NUM_TYPES-1:0] want_up_i,
  // request lines, low means sleep
  output logic [NUM_TYPES-1:0] tier_up_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned low_cnt [NUM_TYPES];
  logic [NUM_TYPES-1:0] w;
  initial tier_up_req_o = '0;
  // wish sampled on the edge, lines moved 1 ns later
  always @(posedge sys_clk_i) begin
    w = want_up_i;
    #1;
    for (int i = 0; i < NUM_TYPES; i++) begin
      if (!rst_b_i) begin
        tier_up_req_o[i] = 1'b0;
        low_cnt[i] = MIN_LOW;
      end else if (tier_up_req_o[i] && !w[i]) begin
        tier_up_req_o[i] = 1'b0;
        low_cnt[i] = 0;
      end else if (!tier_up_req_o[i] && low_cnt[i] < MIN_LOW) begin
        low_cnt[i]++;
      end else begin
        tier_up_req_o[i] = w[i];
      end
    end
  end
endmodule : rgds_host_model

// ---- verif/tb_rail_group_delay_sequencer.sv ----
// Purpose: self-checking bench for the group delay sequencer
// Assumes: short timebase tick of TL cycles
// Notes: walk lengths allow one tick of phase jitter
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_rail_group_delay_sequencer
  import rgds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TL = 4;
  localparam int TK [8] = '{1, 2, 4, 6, 8, 10, 12, 20};
  localparam logic [11:0] NV = {3'h7, 3'h2, 3'h1, 3'h5};
  localparam logic [7:0] AD [4] = '{ADDR_FIRST_TIER_TIM, ADDR_SECOND_TIER_TIM, ADDR_THIRD_TIER_TIM,
    ADDR_FOURTH_TIER_TIM};
  localparam logic [3:0] ST [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  rgds_reg_req_t reg_req = '0;
  logic [7:0] rdata;
  logic [3:0] want_up = 4'h0;
  logic [3:0] tier_req;
  logic [15:0] gidx;
  logic [3:0] pstate;
  logic [3:0] prev_idx [4];
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  rgds_sequencer #(.TICK_LEN(TL)) DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .nv_on_code_i(NV),
    .reg_req_i(reg_req), .reg_rdata_o(rdata), .tier_up_req_i(tier_req), .group_index_o(gidx),
    .power_state_code_o(pstate));
  rgds_host_model #(.MIN_LOW(18 * TK[7] * TL)) host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .want_up_i(want_up), .tier_up_req_o(tier_req));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic in_tol(input int d, input int e);
    return (d + TL >= e) && (d <= e + TL);
  endfunction : in_tol

  // register write, one cycle pulse then one idle cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.wr_en = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(posedge sys_clk_i);
    #1 reg_req.wr_en = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask : reg_wr

  // register read, data checked the cycle after the pulse
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    reg_req.rd_en = 1'b1;
    reg_req.addr = a;
    @(posedge sys_clk_i);
    #1 reg_req.rd_en = 1'b0;
    `CHK("reg_rdata", e, rdata)
    @(posedge sys_clk_i);
    #1;
  endtask : reg_rd

  task automatic wait_idx(input int t, input logic [3:0] v);
    int n;
    n = 0;
    while (gidx[4*t+:4] !== v && n < 3000) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    `CHK("index_reached", v, gidx[4*t+:4])
  endtask : wait_idx

  task automatic walk_up(input int t, input logic [2:0] on, input logic [2:0] off);
    int t0;
    reg_wr(AD[t], {1'b0, off, 1'b0, on});
    reg_rd(AD[t], {1'b0, off, 1'b0, on});
    want_up[t] = 1'b1;
    wait_idx(t, 4'h0);
    t0 = cyc;
    wait_idx(t, LAST_GROUP);
    `CHK("on_walk_len", 1'b1, in_tol(cyc - t0, 14 * TK[on] * TL))
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("state_up", ST[t+1], pstate)
  endtask : walk_up

  task automatic walk_dn(input int t, input logic [2:0] off);
    int t0;
    want_up[t] = 1'b0;
    wait_idx(t, 4'hd);
    t0 = cyc;
    wait_idx(t, GROUP_DISABLED);
    `CHK("off_walk_len", 1'b1, in_tol(cyc - t0, 14 * TK[off] * TL))
    `CHK("state_dn", ST[t], pstate)
  endtask : walk_dn

  // every index move goes one step in the requested direction, looked at once outputs settle
  always @(posedge sys_clk_i) begin
    #2;
    for (int i = 0; i < 4; i++) begin
      if (rst_b_i && gidx[4*i+:4] !== prev_idx[i]) begin
        `CHK("step_dir", (tier_req[i] ? prev_idx[i] + 4'h1 : prev_idx[i] - 4'h1), gidx[4*i+:4])
      end
      prev_idx[i] = gidx[4*i+:4];
    end
  end

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc >= 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("idx_rst", 16'hffff, gidx)
    `CHK("state_rst", 4'h0, pstate)
    for (int t = 0; t < 4; t++) reg_rd(AD[t], {1'b0, NV[3*t+:3], 1'b0, NV[3*t+:3]});
    reg_wr(8'hc5, 8'h33);
    reg_rd(8'hc5, 8'h00);
    reg_wr(AD[0], 8'hff);
    reg_rd(AD[0], 8'h77);
    for (int t = 0; t < 4; t++) walk_up(t, 3'(2 * t), 3'(7 - 2 * t));
    for (int t = 3; t >= 0; t--) walk_dn(t, 3'(7 - 2 * t));
    // mid-run reset brings back the nonvolatile codes over a host write
    reg_wr(AD[1], 8'h00);
    rst_b_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CHK("idx_rerst", 16'hffff, gidx)
    `CHK("state_rerst", 4'h0, pstate)
    reg_rd(AD[1], {1'b0, NV[5:3], 1'b0, NV[5:3]});
    report_and_stop();
  end
endmodule : tb_rail_group_delay_sequencer
